//--- common/strap_clk_pkg.sv
// package: constants, types and bus carriers of the strap, clock-out and reset block
package strap_clk_pkg;
  // timing
  localparam int CLK_NS = 100;
  localparam int UT_NS = 100;
  localparam int SETTLE_UT = 8;
  localparam int SETTLE_CYC = (SETTLE_UT * UT_NS) / CLK_NS;
  localparam int INIT_CYC = 1025;
  localparam int INIT_W = 11;
  localparam logic [INIT_W-1:0] INIT_LAST = INIT_W'(INIT_CYC - 1);
  // register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_GEN_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_GEN_ENABLE = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_START_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_START_ENABLE = 8'h14;
  // field positions
  localparam int CTRL_JOIN_BIT = 0;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_HALT_BIT = 2;
  localparam int ST_INIT_BIT = 3;
  localparam int ST_SEL_LSB = 4;
  localparam int ST_JOIN_BIT = 6;
  // reset values
  localparam logic CTRL_JOIN_RST = 1'b0;
  localparam logic IRQ_N_RST = 1'b1;
  // strap encodings
  localparam logic [1:0] STRAP_ASYNC = 2'h0;
  localparam logic [1:0] STRAP_SYNC = 2'h1;
  localparam logic [1:0] CSEL_OFF = 2'h0;
  localparam logic [1:0] CSEL_SLOW = 2'h1;
  localparam logic [1:0] CSEL_MID = 2'h2;
  localparam logic [1:0] CSEL_FAST = 2'h3;
  // divider half periods in device clocks
  localparam int DIV_W = 8;
  localparam int HALF_SLOW_DEF = 5;
  localparam int HALF_MID_DEF = 2;
  localparam int HALF_FAST_DEF = 1;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    no_host_mode, async_memory_host_mode, sync_mcu_host_mode, unsupported_host_mode
  } host_mode_e;

  typedef enum logic [1:0] {seq_capture, seq_init, seq_run, seq_halt} seq_e;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_s;
endpackage : strap_clk_pkg

//--- hdl/irq_bank.sv
// sticky interrupt status bank gated by an enable mask
module irq_bank #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic rst,
  // event sources
  input wire logic [W-1:0] events,
  // software access
  input wire logic wr_status,
  input wire logic wr_enable,
  input wire logic [W-1:0] wdata,
  // state
  output logic [W-1:0] status,
  output logic [W-1:0] enable,
  output logic pending
);
  import strap_clk_pkg::*;

  typedef struct packed {
    logic [W-1:0] status;
    logic [W-1:0] enable;
  } bank_s;

  bank_s s;
  bank_s next_s;
  logic [W-1:0] clr;

  always_comb begin
    next_s = s;
    clr = wr_status ? wdata : {W{1'b0}};
    if (wr_enable) begin
      next_s.enable = wdata;
    end
    // write one to clear; an event in the same cycle keeps its bit
    next_s.status = (s.status & ~clr) | events;
  end

  always_ff @(posedge aclk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign status = s.status;
  assign enable = s.enable;
  assign pending = |(s.status & s.enable);

  default clocking cb @(posedge aclk); endclocking

  property p_set_wins;
    disable iff (rst) (|events) |=> ((status & $past(events)) == $past(events));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost on clear");

  property p_hold_unwritten;
    disable iff (rst) (!wr_status && events == '0) |=> $stable(status);
  endproperty
  a_hold_unwritten: assert property (p_hold_unwritten) else $error("status moved alone");
endmodule : irq_bank

//--- hdl/host_clk_div.sv
// host clock divider with strap-selected ratio and phase restart
module host_clk_div #(
  parameter int HALF_SLOW = strap_clk_pkg::HALF_SLOW_DEF,
  parameter int HALF_MID = strap_clk_pkg::HALF_MID_DEF,
  parameter int HALF_FAST = strap_clk_pkg::HALF_FAST_DEF
) (
  // clock and internal reset
  input wire logic aclk,
  input wire logic rst,
  // selection
  input wire logic [1:0] sel,
  input wire logic restart,
  // clock out
  output logic clk_out
);
  import strap_clk_pkg::*;

  localparam int SETTLE_LIM = SETTLE_CYC;

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic clk;
  } div_s;

  div_s s;
  div_s next_s;
  logic [DIV_W-1:0] half_last;

  always_comb begin
    half_last = '0;
    case (sel)
      CSEL_SLOW: half_last = DIV_W'(HALF_SLOW - 1);
      CSEL_MID: half_last = DIV_W'(HALF_MID - 1);
      CSEL_FAST: half_last = DIV_W'(HALF_FAST - 1);
      default: half_last = '0;
    endcase
  end

  always_comb begin
    next_s = s;
    // restart realigns the phase so a new ratio never yields a runt half
    if (sel == CSEL_OFF || restart) begin
      next_s.cnt = '0;
      next_s.clk = 1'b0;
    end else if (s.cnt == half_last) begin
      next_s.cnt = '0;
      next_s.clk = ~s.clk;
    end else begin
      next_s.cnt = DIV_W'(s.cnt + 1'b1);
    end
  end

  always_ff @(posedge aclk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign clk_out = s.clk;

  default clocking cb @(posedge aclk); endclocking

  property p_off_low;
    disable iff (rst) (sel == CSEL_OFF) |=> !clk_out;
  endproperty
  a_off_low: assert property (p_off_low) else $error("clock runs while off");

  sequence s_restart_on;
    restart && sel != CSEL_OFF;
  endsequence
  property p_settle;
    disable iff (rst) s_restart_on ##1 (!restart && $stable(sel)) [*7] |-> ##[0:SETTLE_LIM] clk_out;
  endproperty
  a_settle: assert property (p_settle) else $error("clock not settled");
endmodule : host_clk_div

//--- hdl/strap_latch_host_clk_out_reset.sv
// strap capture, host clock output, reset sequencing and interrupt line of the controller
// Operation
// - latch both host-port straps on leaving hard reset; hold until next reset, hard or internal.
// - pick asynchronous-memory or synchronous-bus host mode from the latched straps.
// - unsupported strap code halts everything but the host clock; no host transaction is taken or answered.
// - after an unsupported code stay in configuration mode; never join the network.
// - host clock is off or runs at one of three strap-chosen rates.
// - host clock keeps running in every state, hard reset included, unless it is selected off or held by internal reset.
// - host clock is suppressed while power-on or low-voltage reset is active.
// - the two clock-select straps enable the host clock and choose its rate.
// - host clock is stable within 8 microticks after hard reset release.
// - all interrupt sources combine onto one host interrupt line.
// - interrupt is a level held while an enabled cause stays pending.
// - reset comes from the hard reset input or the internal detectors.
// - every reset returns all registers and control bits to startup values, except that hard reset keeps the clock select and the host clock divider state.
// - causes live in general and startup status registers, each with an enable.
// - interrupt line low requests service, high means nothing pending.
// - straps sampled in the first cycle after reset release with shared driver off and pulldown on.
// - a 1025-cycle initialization runs after leaving any reset, unless the latched straps are unsupported.
module strap_latch_host_clk_out_reset #(
  parameter int GEN_W = 8,
  parameter int START_W = 8,
  parameter int HALF_SLOW = strap_clk_pkg::HALF_SLOW_DEF,
  parameter int HALF_MID = strap_clk_pkg::HALF_MID_DEF,
  parameter int HALF_FAST = strap_clk_pkg::HALF_FAST_DEF
) (
  // clock and resets
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic por_active,
  input wire logic lvr_active,
  // register bus
  input strap_clk_pkg::axi_req_s axi_req,
  output strap_clk_pkg::axi_rsp_s axi_rsp,
  // host-port straps, high one shared with a transmit pin
  input wire logic host_port_strap_lo,
  input wire logic host_port_strap_hi_i,
  output logic host_port_strap_hi_o,
  output logic host_port_strap_hi_oe,
  output logic strap_pulldown_en,
  input wire logic phy_tx_data,
  // clock select straps and host clock
  input wire logic [1:0] clk_sel_strap,
  output logic host_clk_out,
  // interrupt sources and line
  input wire logic [GEN_W-1:0] gen_events,
  input wire logic [START_W-1:0] startup_events,
  output logic irq_out_n,
  // operating status
  output strap_clk_pkg::host_mode_e host_mode,
  output logic init_busy,
  output logic op_halted,
  output logic config_mode,
  output logic net_join_en
);
  import strap_clk_pkg::*;

  localparam int TOGGLE_LIM = 2 * HALF_SLOW + 2;

  typedef struct packed {
    seq_e seq;
    host_mode_e host_mode;
    logic [1:0] strap;
    logic [1:0] csel;
    logic csel_ok;
    logic restart;
    logic [INIT_W-1:0] init_cnt;
    logic net_join;
    logic irq_n;
    logic aw_got;
    logic [ADDR_W-1:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } top_s;

  top_s s;
  top_s next_s;
  logic rst_int;
  logic rst_all;
  logic run;
  logic awready;
  logic wready;
  logic arready;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic [31:0] rd;
  logic rd_err;
  logic gen_wr_status;
  logic gen_wr_enable;
  logic start_wr_status;
  logic start_wr_enable;
  logic [GEN_W-1:0] gen_status;
  logic [GEN_W-1:0] gen_enable;
  logic gen_pending;
  logic [START_W-1:0] start_status;
  logic [START_W-1:0] start_enable;
  logic start_pending;
  logic [GEN_W-1:0] gen_ev;
  logic [START_W-1:0] start_ev;

  assign rst_int = por_active | lvr_active;
  assign rst_all = rst_int | ~aresetn;
  assign run = (s.seq == seq_run);

  // a halted or initializing device takes nothing from the bus
  assign awready = run && !s.aw_got && !s.bvalid;
  assign wready = run && !s.w_got && !s.bvalid;
  assign arready = run && !s.rvalid;
  assign aw_hs = axi_req.awvalid && awready;
  assign w_hs = axi_req.wvalid && wready;
  assign ar_hs = axi_req.arvalid && arready;

  // sources stop with the rest of the device when it is not running
  assign gen_ev = gen_events & {GEN_W{run}};
  assign start_ev = startup_events & {START_W{run}};

  always_comb begin
    next_s = s;
    next_s.restart = 1'b0;
    gen_wr_status = 1'b0;
    gen_wr_enable = 1'b0;
    start_wr_status = 1'b0;
    start_wr_enable = 1'b0;
    rd = '0;
    rd_err = 1'b0;

    // clock select taken after internal reset and again at each hard release
    if (!s.csel_ok || (aresetn && s.seq == seq_capture)) begin
      next_s.csel = clk_sel_strap;
      next_s.csel_ok = 1'b1;
      next_s.restart = 1'b1;
    end

    case (s.seq)
      seq_capture: begin
        // first cycle after release; pin driver still off here
        next_s.strap = {host_port_strap_hi_i, host_port_strap_lo};
        next_s.init_cnt = '0;
        if ({host_port_strap_hi_i, host_port_strap_lo} == STRAP_ASYNC) begin
          next_s.host_mode = async_memory_host_mode;
          next_s.seq = seq_init;
        end else if ({host_port_strap_hi_i, host_port_strap_lo} == STRAP_SYNC) begin
          next_s.host_mode = sync_mcu_host_mode;
          next_s.seq = seq_init;
        end else begin
          next_s.host_mode = unsupported_host_mode;
          next_s.seq = seq_halt;
        end
      end
      seq_init: begin
        next_s.init_cnt = INIT_W'(s.init_cnt + 1'b1);
        if (s.init_cnt == INIT_LAST) begin
          next_s.seq = seq_run;
        end
      end
      seq_run: begin
        next_s.seq = seq_run;
      end
      default: begin
        // only a reset leaves the halt
        next_s.seq = seq_halt;
      end
    endcase

    // write address and data in either order
    if (aw_hs) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = axi_req.awaddr;
    end
    if (w_hs) begin
      next_s.w_got = 1'b1;
      next_s.wdata = axi_req.wdata;
      next_s.wstrb = axi_req.wstrb;
    end
    if (s.aw_got && s.w_got) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      // all fields sit in byte lane 0
      if (s.awaddr == OFS_CTRL) begin
        if (s.wstrb[0]) begin
          next_s.net_join = s.wdata[CTRL_JOIN_BIT];
        end
      end else if (s.awaddr == OFS_STATUS) begin
        next_s.bresp = RESP_OKAY;
      end else if (s.awaddr == OFS_GEN_STATUS) begin
        gen_wr_status = s.wstrb[0];
      end else if (s.awaddr == OFS_GEN_ENABLE) begin
        gen_wr_enable = s.wstrb[0];
      end else if (s.awaddr == OFS_START_STATUS) begin
        start_wr_status = s.wstrb[0];
      end else if (s.awaddr == OFS_START_ENABLE) begin
        start_wr_enable = s.wstrb[0];
      end else begin
        next_s.bresp = RESP_SLVERR;
      end
    end else if (s.bvalid && axi_req.bready) begin
      next_s.bvalid = 1'b0;
    end

    // read decode
    if (axi_req.araddr == OFS_CTRL) begin
      rd[CTRL_JOIN_BIT] = s.net_join;
    end else if (axi_req.araddr == OFS_STATUS) begin
      rd[ST_MODE_LSB +: 2] = s.host_mode;
      rd[ST_HALT_BIT] = (s.seq == seq_halt);
      rd[ST_INIT_BIT] = run;
      rd[ST_SEL_LSB +: 2] = s.csel;
      rd[ST_JOIN_BIT] = run && s.net_join;
    end else if (axi_req.araddr == OFS_GEN_STATUS) begin
      rd[GEN_W-1:0] = gen_status;
    end else if (axi_req.araddr == OFS_GEN_ENABLE) begin
      rd[GEN_W-1:0] = gen_enable;
    end else if (axi_req.araddr == OFS_START_STATUS) begin
      rd[START_W-1:0] = start_status;
    end else if (axi_req.araddr == OFS_START_ENABLE) begin
      rd[START_W-1:0] = start_enable;
    end else begin
      rd_err = 1'b1;
    end
    if (ar_hs) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rd;
      next_s.rresp = rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s.rvalid && axi_req.rready) begin
      next_s.rvalid = 1'b0;
    end

    // one level line for both banks, low while anything enabled is pending
    next_s.irq_n = !(gen_pending || start_pending);
  end

  always_ff @(posedge aclk) begin
    if (rst_int) begin
      s <= '0;
      s.net_join <= CTRL_JOIN_RST;
      s.irq_n <= IRQ_N_RST;
    end else if (!aresetn) begin
      // hard reset leaves the clock select alone so the host clock keeps going
      s <= '0;
      s.net_join <= CTRL_JOIN_RST;
      s.irq_n <= IRQ_N_RST;
      s.csel <= next_s.csel;
      s.csel_ok <= next_s.csel_ok;
      s.restart <= next_s.restart;
    end else begin
      s <= next_s;
    end
  end

  irq_bank #(
    .W(GEN_W)
  ) u_gen_bank (
    .aclk(aclk),
    .rst(rst_all),
    .events(gen_ev),
    .wr_status(gen_wr_status),
    .wr_enable(gen_wr_enable),
    .wdata(s.wdata[GEN_W-1:0]),
    .status(gen_status),
    .enable(gen_enable),
    .pending(gen_pending)
  );

  irq_bank #(
    .W(START_W)
  ) u_start_bank (
    .aclk(aclk),
    .rst(rst_all),
    .events(start_ev),
    .wr_status(start_wr_status),
    .wr_enable(start_wr_enable),
    .wdata(s.wdata[START_W-1:0]),
    .status(start_status),
    .enable(start_enable),
    .pending(start_pending)
  );

  // only the internal detectors stop the divider
  host_clk_div #(
    .HALF_SLOW(HALF_SLOW),
    .HALF_MID(HALF_MID),
    .HALF_FAST(HALF_FAST)
  ) u_clk_div (
    .aclk(aclk),
    .rst(rst_int),
    .sel(s.csel),
    .restart(s.restart),
    .clk_out(host_clk_out)
  );

  assign axi_rsp.awready = awready;
  assign axi_rsp.wready = wready;
  assign axi_rsp.bvalid = s.bvalid;
  assign axi_rsp.bresp = s.bresp;
  assign axi_rsp.arready = arready;
  assign axi_rsp.rvalid = s.rvalid;
  assign axi_rsp.rdata = s.rdata;
  assign axi_rsp.rresp = s.rresp;

  // shared pin released and pulled down until supported straps are in; it stays released in the halt
  assign host_port_strap_hi_oe = aresetn && (s.seq == seq_init || run);
  assign host_port_strap_hi_o = phy_tx_data;
  assign strap_pulldown_en = !host_port_strap_hi_oe;
  assign irq_out_n = s.irq_n;
  assign host_mode = s.host_mode;
  assign init_busy = (s.seq == seq_init);
  assign op_halted = (s.seq == seq_halt);
  assign net_join_en = run && s.net_join;
  assign config_mode = !net_join_en;

  default clocking cb @(posedge aclk); endclocking

  property p_strap_hold;
    disable iff (rst_all) (s.seq != seq_capture) |=> $stable(s.strap) && $stable(host_mode);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("straps changed after capture");

  property p_mode_decode;
    disable iff (rst_all) (s.seq == seq_capture) |=>
      ((s.seq == seq_halt) == (host_mode == unsupported_host_mode));
  endproperty
  a_mode_decode: assert property (p_mode_decode) else $error("mode and halt disagree");

  property p_halt_silent;
    disable iff (rst_all) op_halted |->
      !axi_rsp.awready && !axi_rsp.wready && !axi_rsp.arready && !axi_rsp.bvalid
      && !axi_rsp.rvalid;
  endproperty
  a_halt_silent: assert property (p_halt_silent) else $error("halted device answered");

  property p_halt_stays;
    disable iff (rst_all) op_halted |=> op_halted && config_mode && !net_join_en;
  endproperty
  a_halt_stays: assert property (p_halt_stays) else $error("left halt without reset");

  sequence s_init_last;
    init_busy && s.init_cnt == INIT_LAST;
  endsequence
  property p_init_len;
    disable iff (rst_all) s_init_last |=> run && !init_busy;
  endproperty
  a_init_len: assert property (p_init_len) else $error("init length wrong");

  property p_init_early;
    disable iff (rst_all) (init_busy && s.init_cnt != INIT_LAST) |=> init_busy;
  endproperty
  a_init_early: assert property (p_init_early) else $error("init ended early");

  property p_clk_gated;
    @(posedge aclk) rst_int |=> !host_clk_out;
  endproperty
  a_clk_gated: assert property (p_clk_gated) else $error("clock during internal reset");

  property p_clk_in_hard_reset;
    @(posedge aclk) disable iff (rst_int)
      (!aresetn && s.csel_ok && s.csel != CSEL_OFF) |->
      ##[1:TOGGLE_LIM] ($changed(host_clk_out) || aresetn);
  endproperty
  a_clk_in_hard_reset: assert property (p_clk_in_hard_reset) else $error("clock stopped");

  property p_irq_asserts;
    disable iff (rst_all) (gen_pending || start_pending) [*2] |-> !irq_out_n;
  endproperty
  a_irq_asserts: assert property (p_irq_asserts) else $error("pending cause not shown");

  property p_irq_idle;
    disable iff (rst_all) !(gen_pending || start_pending) |=> irq_out_n;
  endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("line low with nothing pending");

  property p_hard_reset;
    @(posedge aclk) !aresetn |=> (s.seq == seq_capture) && irq_out_n && !net_join_en;
  endproperty
  a_hard_reset: assert property (p_hard_reset) else $error("reset values wrong");
endmodule : strap_latch_host_clk_out_reset

//--- verif/host_side_model.sv
// host side model: shared strap pin resolution and transmit data source
module host_side_model (
  // clock
  input wire logic aclk,
  // shared strap pin
  input wire logic pin_o,
  input wire logic pin_oe,
  input wire logic pull_up,
  output logic pin_i,
  // transmit data
  output logic tx_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] lfsr = 32'h1;
  // external pullup overrides the weak internal pulldown while released
  assign pin_i = pin_oe ? pin_o : pull_up;
  assign tx_data = lfsr[0];
  always_ff @(posedge aclk) begin
    lfsr <= {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
  end
endmodule : host_side_model

//--- verif/testbench.sv
// self-checking bench of the strap, host clock, reset and interrupt block
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import strap_clk_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, por_active = 1'b1, lvr_active = 1'b0;
  logic strap_lo = 1'b0, pull_up = 1'b0;
  logic [1:0] clk_sel = 2'h1;
  logic [7:0] gen_ev = 8'h0, st_ev = 8'h0;
  axi_req_s req = '0;
  axi_rsp_s rsp;
  logic hi_i, hi_o, hi_oe, pd_en, tx, clk_out, irq_n, busy, halted, cfg, join_en;
  host_mode_e mode;
  int failures = 0, compares = 0, busy_cnt = 0;
  int seed = 32'hDA128838;
  logic [31:0] rdat;
  logic [1:0] resp;
  bit ok;

  strap_latch_host_clk_out_reset u_strap_latch_host_clk_out_reset (.aclk(aclk), .aresetn(aresetn),
    .por_active(por_active), .lvr_active(lvr_active), .axi_req(req), .axi_rsp(rsp),
    .host_port_strap_lo(strap_lo), .host_port_strap_hi_i(hi_i),
    .host_port_strap_hi_o(hi_o), .host_port_strap_hi_oe(hi_oe),
    .strap_pulldown_en(pd_en), .phy_tx_data(tx), .clk_sel_strap(clk_sel),
    .host_clk_out(clk_out), .gen_events(gen_ev), .startup_events(st_ev),
    .irq_out_n(irq_n), .host_mode(mode), .init_busy(busy), .op_halted(halted),
    .config_mode(cfg), .net_join_en(join_en));
  host_side_model u_host_side_model (.aclk(aclk), .pin_o(hi_o), .pin_oe(hi_oe),
    .pull_up(pull_up), .pin_i(hi_i), .tx_data(tx));

  initial forever #(CLK_NS / 2) aclk = ~aclk;
  always @(posedge aclk) if (busy === 1'b1) busy_cnt++;

  function automatic int half(input logic [1:0] s);
    case (s)
      CSEL_SLOW: return HALF_SLOW_DEF;
      CSEL_MID: return HALF_MID_DEF;
      CSEL_FAST: return HALF_FAST_DEF;
      default: return 0;
    endcase
  endfunction : half

  task automatic end_of_test;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  // a bounded wait lets a halted device be probed without hanging
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input int lim);
    int n;
    @(posedge aclk);
    req.awvalid <= 1'b1; req.awaddr <= a; req.wvalid <= 1'b1;
    req.wdata <= d; req.wstrb <= 4'hF; req.bready <= 1'b1;
    ok = 0;
    for (n = 0; n < lim && !ok; n++) begin
      @(posedge aclk);
      if (req.awvalid && rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready === 1'b1) req.wvalid <= 1'b0;
      if (rsp.bvalid === 1'b1) begin resp = rsp.bresp; ok = 1; end
    end
    req.bready <= 1'b0;
    if (!ok) begin req.awvalid <= 1'b0; req.wvalid <= 1'b0; end
  endtask : wr

  task automatic rd(input logic [7:0] a, input int lim);
    int n;
    @(posedge aclk);
    req.arvalid <= 1'b1; req.araddr <= a; req.rready <= 1'b1;
    ok = 0;
    for (n = 0; n < lim && !ok; n++) begin
      @(posedge aclk);
      if (req.arvalid && rsp.arready === 1'b1) req.arvalid <= 1'b0;
      if (rsp.rvalid === 1'b1) begin rdat = rsp.rdata; resp = rsp.rresp; ok = 1; end
    end
    req.rready <= 1'b0;
    if (!ok) req.arvalid <= 1'b0;
  endtask : rd

  task automatic settle(input bit run);
    int n, t;
    busy_cnt = 0;
    repeat (3) @(posedge aclk);
    t = 0;
    if (half(clk_sel) > 0) begin
      for (n = 0; n < 6 && clk_out !== 1'b1; n++) @(posedge aclk);
      while (clk_out === 1'b1 && t < 20) begin t++; @(posedge aclk); end
      `CHK(t, half(clk_sel))
    end else begin
      repeat (20) begin @(posedge aclk); if (clk_out !== 1'b0) t++; end
      `CHK(t, 0)
    end
    for (n = 0; busy === 1'b1 && n < 1100; n++) @(posedge aclk);
    if (run) begin
      `CHK(busy_cnt, INIT_CYC)
      `CHK(hi_oe, 1'b1)
      `CHK(hi_o, tx)
    end
  endtask : settle

  task automatic hard_reset(input bit run, input bit keep);
    int t;
    logic last;
    @(posedge aclk);
    aresetn <= 1'b0;
    t = 0;
    last = clk_out;
    repeat (20) begin @(posedge aclk); if (clk_out !== last) t++; last = clk_out; end
    if (keep) `CHK(t > 0, 1'b1)
    `CHK(hi_oe, 1'b0)
    `CHK(pd_en, 1'b1)
    `CHK(join_en, 1'b0)
    `CHK(irq_n, 1'b1)
    aresetn <= 1'b1;
    settle(run);
  endtask : hard_reset

  task automatic pulse(input int b, input logic [7:0] x);
    @(posedge aclk);
    if (b) st_ev <= x; else gen_ev <= x;
    @(posedge aclk);
    if (b) st_ev <= 8'h0; else gen_ev <= 8'h0;
  endtask : pulse

  task automatic irq_case(input int b);
    logic [7:0] m, ev, off, so, eo;
    m = 8'($random(seed));
    if (m == 8'h0) m = 8'h80;
    ev = m & (~m + 8'h1);
    off = ~m & (m + 8'h1);
    so = b ? OFS_START_STATUS : OFS_GEN_STATUS;
    eo = b ? OFS_START_ENABLE : OFS_GEN_ENABLE;
    // random upper bits must be ignored and read back as zero
    wr(eo, ($random(seed) & 32'hFFFFFF00) | {24'h0, m}, 100);
    rd(eo, 100);
    `CHK(rdat, {24'h0, m})
    pulse(b, off);
    repeat (4) @(posedge aclk);
    `CHK(irq_n, 1'b1)
    pulse(b, ev);
    repeat (2) @(posedge aclk);
    `CHK(irq_n, 1'b0)
    repeat (6) @(posedge aclk);
    `CHK(irq_n, 1'b0)
    rd(so, 100);
    `CHK(rdat, {24'h0, ev | off})
    wr(so, 32'hFF, 100);
    repeat (3) @(posedge aclk);
    `CHK(irq_n, 1'b1)
    rd(so, 100);
    `CHK(rdat, 32'h0)
  endtask : irq_case

  initial begin
    #3_000_000;
    failures++;
    end_of_test;
  end

  initial begin
    int i, t;
    logic [1:0] s, prev;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    por_active <= 1'b0;
    settle(1'b1);
    `CHK(mode, async_memory_host_mode)
    strap_lo <= 1'b1;
    pull_up <= 1'b1;
    repeat (5) @(posedge aclk);
    `CHK(mode, async_memory_host_mode)
    strap_lo <= 1'b0;
    pull_up <= 1'b0;
    rd(OFS_STATUS, 100);
    `CHK(rdat[5:0], {CSEL_SLOW, 2'h2, 2'h1})
    for (i = 0; i < 6; i++) begin
      if (i != 1) begin rd(8'(4 * i), 100); `CHK(rdat, 32'h0) end
    end
    rd(8'h40, 100);
    `CHK(resp, RESP_SLVERR)
    wr(OFS_CTRL, 32'h1, 100);
    repeat (2) @(posedge aclk);
    `CHK(cfg, 1'b0)
    for (i = 0; i < 2; i++) irq_case(i);
    prev = 2'h1;
    for (i = 0; i < 4; i++) begin
      s = 2'(8'hB1 >> (6 - 2 * i));
      clk_sel <= s;
      strap_lo <= s[0];
      hard_reset(1'b1, prev != 2'h0);
      `CHK(mode, s[0] ? sync_mcu_host_mode : async_memory_host_mode)
      prev = s;
    end
    for (i = 0; i < 2; i++) begin
      @(posedge aclk);
      if (i == 0) por_active <= 1'b1; else lvr_active <= 1'b1;
      repeat (2) @(posedge aclk);
      t = 0;
      repeat (10) begin @(posedge aclk); if (clk_out !== 1'b0) t++; end
      `CHK(t, 0)
      `CHK(mode, no_host_mode)
      por_active <= 1'b0;
      lvr_active <= 1'b0;
      settle(1'b1);
    end
    pull_up <= 1'b1;
    strap_lo <= 1'b0;
    hard_reset(1'b0, 1'b1);
    `CHK(halted, 1'b1)
    `CHK(mode, unsupported_host_mode)
    rd(OFS_STATUS, 40);
    `CHK(ok, 1'b0)
    wr(OFS_CTRL, 32'h1, 40);
    `CHK(cfg, 1'b1)
    `CHK(join_en, 1'b0)
    pull_up <= 1'b0;
    hard_reset(1'b1, 1'b1);
    `CHK(halted, 1'b0)
    `CHK(mode, async_memory_host_mode)
    end_of_test;
  end
endmodule : testbench
